//--- include/acc_pkg.sv
/*
  Shared constants and types of the converter control block.
  Assumes a 100 MHz system clock; the reference settling count is derived from that rate.
*/
package acc_pkg;
  // ----------------------------------------------------------------
  // Clocking and timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_KHZ        = 100000;
  localparam int unsigned CLK_PERIOD_NS  = 1000000 / SYS_KHZ;
  localparam int unsigned OSC_KHZ        = 1024;
  localparam int unsigned MOD_DIV        = 4;
  localparam int unsigned REF_SETTLE_NS  = 25000;
  localparam int unsigned REF_SETTLE_CYC =
    (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Conversion lengths in oscillator periods, one per data rate.
  localparam int unsigned CONV_TCLK_20   = 51192;
  localparam int unsigned CONV_TCLK_90   = 11532;
  localparam int unsigned CONV_TCLK_330  = 3116;
  localparam int unsigned CONV_TCLK_1000 = 1036;
  localparam int unsigned SCALE_NUM      = 32'h4000_0000;
  localparam int unsigned SCALE_SHIFT    = 15;
  // ----------------------------------------------------------------
  // Configuration register layout
  // ----------------------------------------------------------------
  localparam int unsigned CODE_W   = 16;
  localparam int unsigned CFG_W    = 8;
  localparam int unsigned MUX_LSB  = 5;
  localparam int unsigned MUX_W    = 3;
  localparam int unsigned GAIN_BIT = 4;
  localparam int unsigned DR_LSB   = 2;
  localparam int unsigned DR_W     = 2;
  localparam int unsigned CM_BIT   = 1;
  localparam int unsigned VREF_BIT = 0;
  localparam logic [7:0]  CFG_RESET = 8'h00;
  localparam logic [2:0]  MUX_SE_LO = 3'h3;
  localparam logic [2:0]  MUX_SE_HI = 3'h6;
  // ----------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_RESET = 3'h0,
    CMD_START = 3'h1,
    CMD_PDOWN = 3'h2,
    CMD_RDATA = 3'h3,
    CMD_RREG  = 3'h4,
    CMD_WREG  = 3'h5
  } acc_cmd_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SETTLE = 2'h1,
    ST_CONV   = 2'h3
  } acc_state_t;
endpackage

//--- core/acc_decim.sv
/*
  Decimating filter: counts the modulator bitstream over one conversion
  and scales the sum to a signed full-scale code.
  Assumes mod_bit is already synchronous to sys_clk.
*/
module acc_decim #(
  parameter int unsigned CODE_W = acc_pkg::CODE_W
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              restart,
  input  wire logic              running,
  input  wire logic              mod_tick,
  input  wire logic              mod_bit,
  input  wire logic [1:0]        rate_sel,
  output logic                   done_q,
  output logic [CODE_W-1:0]      code_q
);
  import acc_pkg::*;

  localparam int unsigned CNT_W = 14;

  logic        [CNT_W-1:0] len;
  logic        [CNT_W-1:0] cnt_q;
  logic        [23:0]      k;
  logic signed [CNT_W+1:0] acc_q;
  logic signed [CNT_W+1:0] acc_d;
  logic signed [47:0]      prod;
  logic signed [47:0]      scaled;

  if (CODE_W != 16) begin : g_chk
    $error("acc_decim scaling only serves 16-bit codes");
  end

  always_comb begin
    unique case (rate_sel)
      2'h0: len = CNT_W'(CONV_TCLK_20 / MOD_DIV);
      2'h1: len = CNT_W'(CONV_TCLK_90 / MOD_DIV);
      2'h2: len = CNT_W'(CONV_TCLK_330 / MOD_DIV);
      2'h3: len = CNT_W'(CONV_TCLK_1000 / MOD_DIV);
    endcase
    k      = 24'(SCALE_NUM / 32'(len));
    acc_d  = mod_bit ? acc_q + 16'sh0001 : acc_q - 16'sh0001;
    prod   = 48'(acc_d) * $signed({24'h00_0000, k});
    scaled = prod >>> SCALE_SHIFT;
  end

  // A full-scale one-density maps to +32767, since k rounds down, so the top limit is not reached.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      acc_q  <= '0;
      done_q <= 1'b0;
      code_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (restart) begin
        cnt_q <= '0;
        acc_q <= '0;
      end else if (running && mod_tick) begin
        if (cnt_q == len - CNT_W'(1)) begin
          cnt_q  <= '0;
          acc_q  <= '0;
          done_q <= 1'b1; // RQ12
          if (scaled > 48'sh0000_0000_7FFF) begin
            code_q <= 16'h7FFF;
          end else if (scaled < -48'sh0000_0000_8000) begin
            code_q <= 16'h8000;
          end else begin
            code_q <= scaled[CODE_W-1:0]; // RQ11
          end
        end else begin
          cnt_q <= cnt_q + CNT_W'(1);
          acc_q <= acc_d;
        end
      end
    end
  end
endmodule

//--- core/acc_conversion_control.sv
/*
  Conversion control of a 16-bit delta-sigma converter: configuration
  register, command decode, conversion sequencing, result buffer.
  Assumes a serial front end that presents each decoded command as a
  one-cycle strobe on sys_clk, and a modulator bit on an async pin.
*/
// Contract
// RQ1: All configuration sits in one register, driven by six commands.
// RQ2: Single-shot does one conversion, buffers it, then powers down.
// RQ3: Continuous mode restarts conversion right after each completes.
// RQ4: Result buffer updates atomically; reads see latest finished conversion.
// RQ5: Gain bit selects amplification 1 or 4.
// RQ6: Input select 011 to 110 ties negative input to ground.
// RQ7: Single-ended measurements yield only positive codes.
// RQ8: Reference bit picks internal or external; internal after reset.
// RQ9: Internal reference needs 25 us settling before use; a switch to internal during ST_CONV is not waited for.
// RQ10: Modulator clock is the 1.024 MHz oscillator divided by four.
// RQ11: Results are 16-bit codes proportional to differential input.
// RQ12: Filter turns modulator bitstream into a proportional code.
// RQ13: Mode bit selects conversion mode; host restarts after changing it.
// RQ14: A command acts when its byte completes on the eighth clock fall.
// RQ15: Single-shot write during conversion aborts and restarts one conversion.
// RQ16: Any reset restores defaults and idles until a start command.
// RQ17: Done flag marks each conversion; reading the result clears it.
module acc_conversion_control (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  cmd_valid,
  input  wire acc_pkg::acc_cmd_t     cmd_code,
  input  wire logic [7:0]            cmd_wdata,
  input  wire logic                  mod_bit_in,
  output logic [15:0]                reply_q,
  output logic [15:0]                result_q,
  output logic                       conversion_done_flag_q,
  output logic [7:0]                 config_q,
  output logic                       gain_x4_q,
  output logic [2:0]                 input_select_field_q,
  output logic                       negative_converter_input_gnd_q,
  output logic                       ext_ref_sel_q,
  output logic                       analog_on_q,
  output logic                       ref_ready_q,
  output logic                       modulator_clk_q
);
  import acc_pkg::*;

  localparam int unsigned PH_W  = 17;
  localparam int unsigned REF_W = 12;

  acc_state_t       state_q;
  logic [PH_W-1:0]  phase_q;
  logic             clk_tick_q;
  logic [1:0]       div_q;
  logic             mod_tick_q;
  logic             bit_meta_q;
  logic             bit_sync_q;
  logic [REF_W-1:0] ref_cnt_q;
  logic             pd_pending_q;
  logic             done_evt;
  logic [15:0]      conv_code;
  logic             is_cmd_start;
  logic             is_cmd_reset;
  logic             is_cmd_wreg;
  logic             is_cmd_pdown;
  logic             is_cmd_rdata;
  logic             start_req;
  logic             restart;
  logic             single_ended;
  logic             ref_go_int;

  if (REF_SETTLE_CYC >= (1 << REF_W)) begin : g_chk
    $error("reference settle counter too narrow");
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    is_cmd_start = cmd_valid && (cmd_code == CMD_START); // RQ14
    is_cmd_reset = cmd_valid && (cmd_code == CMD_RESET);
    is_cmd_wreg  = cmd_valid && (cmd_code == CMD_WREG);
    is_cmd_pdown = cmd_valid && (cmd_code == CMD_PDOWN);
    is_cmd_rdata = cmd_valid && (cmd_code == CMD_RDATA);
    // In single-shot mode a write while converting acts as a start.
    start_req    = is_cmd_start ||
                   (is_cmd_wreg && !config_q[CM_BIT] && state_q == ST_CONV); // RQ15
    single_ended = (config_q[MUX_LSB +: MUX_W] >= MUX_SE_LO) &&
                   (config_q[MUX_LSB +: MUX_W] <= MUX_SE_HI);
    ref_go_int   = is_cmd_wreg && config_q[VREF_BIT] && !cmd_wdata[VREF_BIT];
    restart      = !is_cmd_reset &&
                   ((start_req && (state_q == ST_CONV ||
                                   (state_q == ST_IDLE && config_q[VREF_BIT]))) ||
                    (state_q == ST_SETTLE && ref_ready_q) ||
                    (done_evt && config_q[CM_BIT] && !pd_pending_q));
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // The mode bit is read at each completion, so it takes effect when the running conversion ends.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_q <= CFG_RESET; // RQ16
    end else if (is_cmd_reset) begin
      config_q <= CFG_RESET; // RQ16
    end else if (is_cmd_wreg) begin
      config_q <= cmd_wdata; // RQ1 RQ13
    end
  end

  assign gain_x4_q            = config_q[GAIN_BIT]; // RQ5
  assign input_select_field_q = config_q[MUX_LSB +: MUX_W];
  assign ext_ref_sel_q        = config_q[VREF_BIT]; // RQ8

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      negative_converter_input_gnd_q <= 1'b0;
    end else begin
      negative_converter_input_gnd_q <= single_ended; // RQ6
    end
  end

  // ----------------------------------------------------------------
  // Oscillator and modulator clock
  // ----------------------------------------------------------------
  // A phase accumulator gives the 1.024 MHz rate on average; the jitter
  // of one system period is far below one modulator period.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q    <= '0;
      clk_tick_q <= 1'b0;
    end else if (!analog_on_q) begin
      phase_q    <= '0;
      clk_tick_q <= 1'b0;
    end else if (phase_q + PH_W'(OSC_KHZ) >= PH_W'(SYS_KHZ)) begin
      phase_q    <= phase_q + PH_W'(OSC_KHZ) - PH_W'(SYS_KHZ);
      clk_tick_q <= 1'b1;
    end else begin
      phase_q    <= phase_q + PH_W'(OSC_KHZ);
      clk_tick_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q           <= '0;
      mod_tick_q      <= 1'b0;
      modulator_clk_q <= 1'b0;
    end else begin
      mod_tick_q <= 1'b0;
      if (!analog_on_q) begin
        div_q <= '0;
      end else if (clk_tick_q) begin
        div_q      <= div_q + 2'h1;
        mod_tick_q <= (div_q == 2'(MOD_DIV - 1)); // RQ10
      end
      modulator_clk_q <= div_q[1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_meta_q <= 1'b0;
      bit_sync_q <= 1'b0;
    end else begin
      bit_meta_q <= mod_bit_in;
      bit_sync_q <= bit_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Reference settling
  // ----------------------------------------------------------------
  // Settling restarts on leaving power-down and on a switch back to the
  // internal reference; the external reference is taken as ready.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_q   <= '0;
      ref_ready_q <= 1'b0;
    end else if (is_cmd_reset || !analog_on_q || ref_go_int) begin
      ref_cnt_q   <= '0;
      ref_ready_q <= 1'b0;
    end else if (config_q[VREF_BIT]) begin
      ref_ready_q <= 1'b1;
    end else if (ref_cnt_q == REF_W'(REF_SETTLE_CYC - 1)) begin
      ref_ready_q <= 1'b1; // RQ9
    end else begin
      ref_cnt_q <= ref_cnt_q + REF_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_IDLE; // RQ16
      analog_on_q  <= 1'b0;
      pd_pending_q <= 1'b0;
    end else if (is_cmd_reset) begin
      state_q      <= ST_IDLE; // RQ16
      analog_on_q  <= 1'b0;
      pd_pending_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            state_q      <= config_q[VREF_BIT] ? ST_CONV : ST_SETTLE; // RQ9
            analog_on_q  <= 1'b1;
            pd_pending_q <= 1'b0;
          end
        end
        ST_SETTLE: begin
          if (is_cmd_pdown) begin
            state_q     <= ST_IDLE;
            analog_on_q <= 1'b0;
          end else if (ref_ready_q) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (start_req) begin
            pd_pending_q <= 1'b0; // RQ15
          end else if (is_cmd_pdown) begin
            pd_pending_q <= 1'b1;
          end else if (done_evt) begin
            if (!config_q[CM_BIT] || pd_pending_q) begin
              state_q      <= ST_IDLE; // RQ2
              analog_on_q  <= 1'b0;
              pd_pending_q <= 1'b0;
            end
          end
        end
        default: begin
          state_q     <= ST_IDLE;
          analog_on_q <= 1'b0;
        end
      endcase
    end
  end

  acc_decim #(
    .CODE_W   (CODE_W)
  ) u_decim (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .restart  (restart), // RQ3
    .running  (state_q == ST_CONV),
    .mod_tick (mod_tick_q),
    .mod_bit  (bit_sync_q),
    .rate_sel (config_q[DR_LSB +: DR_W]),
    .done_q   (done_evt),
    .code_q   (conv_code)
  );

  // ----------------------------------------------------------------
  // Result buffer, done flag and replies
  // ----------------------------------------------------------------
  // The whole word is replaced in one edge, so a read never sees a mix.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (is_cmd_reset) begin
      result_q <= '0;
    end else if (done_evt && state_q == ST_CONV) begin
      result_q <= (single_ended && conv_code[15]) ? 16'h0000 : conv_code; // RQ4 RQ7
    end
  end

  // A completion in the same cycle as a read wins over the clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_done_flag_q <= 1'b0;
    end else if (done_evt && state_q == ST_CONV) begin
      conversion_done_flag_q <= 1'b1; // RQ17
    end else if (is_cmd_rdata || is_cmd_reset) begin
      conversion_done_flag_q <= 1'b0; // RQ17
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_q <= '0;
    end else if (is_cmd_rdata) begin
      reply_q <= result_q; // RQ4
    end else if (cmd_valid && cmd_code == CMD_RREG) begin
      reply_q <= {8'h00, config_q}; // RQ1
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_reset_cmd;
    @(posedge sys_clk) disable iff (!rst_n)
    is_cmd_reset |=> state_q == ST_IDLE && config_q == CFG_RESET && !analog_on_q;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) // RQ16
    else $error("reset command did not restore defaults");

  property p_single_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    done_evt && state_q == ST_CONV && !config_q[CM_BIT] && !cmd_valid
      |=> state_q == ST_IDLE && !analog_on_q ##1 state_q == ST_IDLE;
  endproperty
  a_single_idle: assert property (p_single_idle) // RQ2
    else $error("single-shot did not power down after conversion");

  property p_cont_restart;
    @(posedge sys_clk) disable iff (!rst_n)
    done_evt && state_q == ST_CONV && config_q[CM_BIT] && !pd_pending_q && !cmd_valid
      |-> restart ##1 state_q == ST_CONV;
  endproperty
  a_cont_restart: assert property (p_cont_restart) // RQ3
    else $error("continuous mode did not restart conversion");

  property p_atomic;
    @(posedge sys_clk) disable iff (!rst_n)
    !$stable(result_q) |-> $past(done_evt) || $past(is_cmd_reset);
  endproperty
  a_atomic: assert property (p_atomic) // RQ4
    else $error("result changed without a completed conversion");

  property p_se_ground;
    @(posedge sys_clk) disable iff (!rst_n)
    is_cmd_wreg && cmd_wdata[MUX_LSB +: MUX_W] >= MUX_SE_LO &&
      cmd_wdata[MUX_LSB +: MUX_W] <= MUX_SE_HI |=> ##1 negative_converter_input_gnd_q;
  endproperty
  a_se_ground: assert property (p_se_ground) // RQ6
    else $error("single-ended input select did not ground negative input");

  property p_se_positive;
    @(posedge sys_clk) disable iff (!rst_n)
    done_evt && state_q == ST_CONV && single_ended && !is_cmd_reset |=> !result_q[15];
  endproperty
  a_se_positive: assert property (p_se_positive) // RQ7
    else $error("single-ended result is negative");

  property p_ref_wait;
    @(posedge sys_clk) disable iff (!rst_n)
    start_req && state_q == ST_IDLE && !config_q[VREF_BIT] && !is_cmd_reset
      |=> state_q == ST_SETTLE && !ref_ready_q ##1 !ref_ready_q;
  endproperty
  a_ref_wait: assert property (p_ref_wait) // RQ9
    else $error("internal reference used without settling");

  property p_mod_div;
    @(posedge sys_clk) disable iff (!rst_n)
    mod_tick_q |=> !mod_tick_q [*8];
  endproperty
  a_mod_div: assert property (p_mod_div) // RQ10
    else $error("modulator tick faster than a quarter of the oscillator");

  property p_wreg_abort;
    @(posedge sys_clk) disable iff (!rst_n)
    is_cmd_wreg && !config_q[CM_BIT] && state_q == ST_CONV |-> restart ##1 state_q == ST_CONV;
  endproperty
  a_wreg_abort: assert property (p_wreg_abort) // RQ15
    else $error("write during single-shot did not restart conversion");

  property p_done_clear;
    @(posedge sys_clk) disable iff (!rst_n)
    is_cmd_rdata && !done_evt |=> !conversion_done_flag_q;
  endproperty
  a_done_clear: assert property (p_done_clear) // RQ17
    else $error("result read did not clear done flag");

  c_single: cover property (@(posedge sys_clk) disable iff (!rst_n)
    done_evt && !config_q[CM_BIT]);
  c_cont: cover property (@(posedge sys_clk) disable iff (!rst_n)
    done_evt && config_q[CM_BIT] ##1 state_q == ST_CONV);
  c_abort: cover property (@(posedge sys_clk) disable iff (!rst_n)
    is_cmd_wreg && state_q == ST_CONV && !config_q[CM_BIT]);
endmodule

//--- tb/acc_host_model.sv
/*
  Behavioural host on the far side of the converter control block.
  Assumes the serial front end is already decoded: each command is one
  strobe cycle, and the modulator pin is a plain level set by the bench.
*/
module acc_host_model
  import acc_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             cmd_valid,
  output acc_pkg::acc_cmd_t cmd_code,
  output logic [7:0]       cmd_wdata,
  output logic             mod_bit_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd_valid  = 1'b0;
    cmd_code   = CMD_RESET;
    cmd_wdata  = 8'h00;
    mod_bit_in = 1'b1;
  end

  // ----------------------------------------------------------------
  // Command strobe
  // ----------------------------------------------------------------
  // Code and data are inverted once released so stale values never match.
  task automatic issue(input acc_cmd_t code, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_wdata = data;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code  = acc_cmd_t'(~code);
    cmd_wdata = ~data;
  endtask

  task automatic set_mod(input logic level);
    @(posedge sys_clk);
    #1;
    mod_bit_in = level;
  endtask
endmodule

//--- tb/tb_top.sv
/*
  Self-checking bench of the converter control block.
  Assumes a 100 MHz clock; one full conversion at the fastest rate is run.
*/
`define CHK(nm, exp, got) \
  begin \
    total_checks = total_checks + 1; \
    if ((got) !== (exp)) begin \
      bad_count = bad_count + 1; \
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module tb_top;
  import acc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk;
  logic        rst_n;
  logic        cmd_valid;
  acc_cmd_t    cmd_code;
  logic [7:0]  cmd_wdata;
  logic        mod_bit_in;
  logic [15:0] reply_q;
  logic [15:0] result_q;
  logic        conversion_done_flag_q;
  logic [7:0]  config_q;
  logic        gain_x4_q;
  logic [2:0]  input_select_field_q;
  logic        negative_converter_input_gnd_q;
  logic        ext_ref_sel_q;
  logic        analog_on_q;
  logic        ref_ready_q;
  logic        modulator_clk_q;
  integer      bad_count = 0;
  integer      total_checks = 0;
  integer      seed = 32'h5FAF;
  integer      toggles = 0;
  integer      k;
  logic [7:0]  cfg;

  acc_conversion_control acc_conversion_control_inst (.*);
  acc_host_model acc_host_model_inst (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .mod_bit_in(mod_bit_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(modulator_clk_q) toggles = toggles + 1;

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic exp_gnd(input logic [2:0] sel);
    return (sel >= MUX_SE_LO) && (sel <= MUX_SE_HI);
  endfunction

  // Constant bitstream: every tick adds the same +1 or -1.
  function automatic logic [15:0] exp_code(input int n, input logic ones, input logic se);
    longint v;
    v = ones ? (longint'(n) * 32768) / n : -(longint'(n) * 32768) / n;
    if (se && v < 0) v = 0;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  task automatic cmd(input acc_cmd_t c, input logic [7:0] d);
    acc_host_model_inst.issue(c, d);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #1_600_000;
    bad_count = bad_count + 1;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cycles(2);
    rst_n = 1'b1;
    toggles = 0;
    cycles(500);
    `CHK("config", 8'h00, config_q)
    `CHK("ext_ref", 1'b0, ext_ref_sel_q)
    `CHK("analog_on", 1'b0, analog_on_q)
    `CHK("done_flag", 1'b0, conversion_done_flag_q)
    `CHK("idle_mod_toggles", 0, toggles)
    $display("test reset_defaults done");

    for (int i = 0; i < 8; i++) begin
      cfg = {i[2:0], 5'($random(seed))};
      cmd(CMD_WREG, cfg);
      `CHK("config", cfg, config_q)
      `CHK("gain", cfg[GAIN_BIT], gain_x4_q)
      `CHK("input_sel", cfg[7:5], input_select_field_q)
      `CHK("ext_ref", cfg[VREF_BIT], ext_ref_sel_q)
      cycles(1);
      `CHK("neg_gnd", exp_gnd(cfg[7:5]), negative_converter_input_gnd_q)
      cmd(CMD_RREG, 8'($random(seed)));
      `CHK("rreg", {8'h00, cfg}, reply_q)
    end
    cmd(acc_cmd_t'(3'h6), ~cfg);
    cmd(acc_cmd_t'(3'h7), ~cfg);
    `CHK("undef_cmd", cfg, config_q)
    $display("test config_fields done");

    cmd(CMD_WREG, 8'h0C);
    cmd(CMD_START, 8'h00);
    toggles = 0;
    `CHK("analog_on", 1'b1, analog_on_q)
    cycles(1953);
    `CHK("mod_toggles", 1'b1, toggles >= 9 && toggles <= 11)
    cycles(440);
    `CHK("ref_early", 1'b0, ref_ready_q)
    for (k = 0; k < 200 && ref_ready_q !== 1'b1; k++) cycles(1);
    `CHK("ref_ready", 1'b1, ref_ready_q)
    cmd(CMD_RESET, 8'h00);
    cycles(1);
    `CHK("cmd_reset_cfg", 8'h00, config_q)
    `CHK("cmd_reset_on", 1'b0, analog_on_q)
    $display("test ref_settle done");

    acc_host_model_inst.set_mod(1'b1);
    cmd(CMD_WREG, 8'h0D);
    cmd(CMD_START, 8'h00);
    cycles(2000);
    // The restart runs single-ended on a negative stream, so only the clamp gives zero.
    acc_host_model_inst.set_mod(1'b0);
    cmd(CMD_WREG, 8'h6D);
    cycles(100000);
    `CHK("restart_flag", 1'b0, conversion_done_flag_q)
    for (k = 0; k < 3000 && conversion_done_flag_q !== 1'b1; k++) cycles(1);
    `CHK("done_flag", 1'b1, conversion_done_flag_q)
    `CHK("result", exp_code(259, 1'b0, 1'b1), result_q)
    `CHK("low_power", 1'b0, analog_on_q)
    cmd(CMD_RDATA, 8'h00);
    `CHK("rdata", exp_code(259, 1'b0, 1'b1), reply_q)
    `CHK("flag_clear", 1'b0, conversion_done_flag_q)
    $display("test single_conversion done");

    cmd(CMD_WREG, 8'h6F);
    cmd(CMD_START, 8'h00);
    cycles(100);
    `CHK("continuous_on", 1'b1, analog_on_q)
    cmd(CMD_PDOWN, 8'h00);
    cycles(2);
    `CHK("pdown_finishes", 1'b1, analog_on_q)
    rst_n = 1'b0;
    cycles(2);
    rst_n = 1'b1;
    `CHK("pin_reset_on", 1'b0, analog_on_q)
    `CHK("pin_reset_cfg", 8'h00, config_q)
    $display("test continuous_reset done");
    give_verdict();
  end
endmodule
